// ===== bench/txb_local_irq_i2c_cfg_regs_test.sv
module txb_local_irq_i2c_cfg_regs_test;
   timeunit 1ns;
   timeprecision 1ps;
   import txbli_pkg::*;
   logic clock_in = 1'b0;
   logic srst_in = 1'b1;
   logic target = 1'b1; // Node role pin
   logic [3:0] ev = 4'h0; // Mailbox event pulses
   logic wr, rd, loc, rv, irq, ovr, rate;
   logic [7:0] addr, wdata, rdata;
   logic [1:0] lvl;
   logic [7:0] exp_q[$]; // Expected read data, oldest first
   logic [1:0] lv[4] = '{2'h0, 2'h2, 2'h3, 2'h1};
   logic [31:0] rnd;
   int mismatches = 0;
   int checks_done = 0;
   // 25 MHz clock
   always #20 clock_in = ~clock_in;
   txbli_proc_model pm_u (.clock_in(clock_in), .reg_wr_out(wr),
      .reg_rd_out(rd), .reg_from_local_out(loc), .reg_addr_out(addr),
      .reg_wdata_out(wdata));
   txbli_regs dut_u (.clock_in(clock_in), .srst_in(srst_in),
      .node_is_target_in(target), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_from_local_in(loc), .reg_addr_in(addr), .reg_wdata_in(wdata),
      .reg_rdata_out(rdata), .reg_rvalid_out(rv), .mbox0_full_in(ev[0]),
      .mbox0_empty_in(ev[1]), .mbox1_full_in(ev[2]),
      .mbox1_empty_in(ev[3]), .irq_out(irq),
      .tx_b_override_enable_out(ovr), .tx_b_drive_level_out(lvl),
      .audio_sample_rate_select_out(rate));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Note the expected byte, then issue the read
   task automatic rd_reg(input logic [7:0] a, input logic l,
         input logic [7:0] e);
      exp_q.push_back(e);
      pm_u.access(1'b0, 1'b1, l, a, 8'h00);
   endtask : rd_reg
   // Pulse one set of mailbox events and let the pin settle
   task automatic pulse(input logic [3:0] e);
      @(negedge clock_in);
      ev = e;
      @(negedge clock_in);
      ev = 4'h0;
      @(negedge clock_in);
   endtask : pulse
   task automatic results;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : results
   // Read results pair with the oldest note; an unasked one is an X
   always @(negedge clock_in) begin
      if (rv === 1'b1) chk(rdata, exp_q.size() ? exp_q.pop_front() : 'x);
   end
   initial begin
      rnd = $urandom(32'h9c6bc921);
      repeat (6) @(negedge clock_in);
      srst_in = 1'b0;
      // Every drive level with override set, reserved falls back
      foreach (lv[i]) begin
         pm_u.access(1'b1, 1'b0, 1'b1, ADDR_LINE_TX_B_CONTROL,
            {1'b1, 5'h1f, lv[i]});
         repeat (2) @(negedge clock_in);
         chk({ovr, 5'h0, lvl}, {1'b1, 5'h0, lv[i] == 2'h1 ?
            DEFAULT_TX_B_LEVEL : lv[i]});
         rd_reg(ADDR_LINE_TX_B_CONTROL, 1'b0, {1'b1, 5'h0, lv[i]});
      end
      // Override off hides the stored level
      pm_u.access(1'b1, 1'b0, 1'b0, ADDR_LINE_TX_B_CONTROL, 8'h03);
      repeat (2) @(negedge clock_in);
      chk({ovr, 5'h0, lvl}, 8'h00);
      // Rate bit both ways, random neighbours must not stick
      for (int b = 0; b < 2; b++) begin
         rnd = $urandom;
         pm_u.access(1'b1, 1'b0, 1'b0, ADDR_SERIAL_PORT_CONFIG,
            {rnd[7:3], b[0], rnd[1:0]});
         rd_reg(ADDR_SERIAL_PORT_CONFIG, 1'b1, {5'h0, b[0], 2'h0});
         chk({rate, lvl}, {b[0], 2'h0});
      end
      // Each mailbox event; host read keeps it, local read clears it
      for (int i = 0; i < 4; i++) begin
         pulse(4'h1 << i);
         chk(irq, 8'h01);
         rd_reg(ADDR_LOCAL_INTERRUPT_CAUSE, 1'b0, 8'h30 + i);
         chk(irq, 8'h01);
         rd_reg(ADDR_LOCAL_INTERRUPT_CAUSE, 1'b1, 8'h30 + i);
         @(negedge clock_in);
         chk(irq, 8'h00);
      end
      // Simultaneous events keep the lowest code
      pulse(4'hc);
      rd_reg(ADDR_LOCAL_INTERRUPT_CAUSE, 1'b1, CAUSE_MBOX1_FULL);
      // Event in the clearing read's cycle wins, pin stays up
      pulse(4'h1);
      fork
         rd_reg(ADDR_LOCAL_INTERRUPT_CAUSE, 1'b1, CAUSE_MBOX0_FULL);
         begin
            @(negedge clock_in);
            ev = 4'h2;
            @(negedge clock_in);
            ev = 4'h0;
         end
      join
      chk(irq, 8'h01);
      @(negedge clock_in);
      chk(irq, 8'h01);
      rd_reg(ADDR_LOCAL_INTERRUPT_CAUSE, 1'b1, CAUSE_MBOX0_EMPTY);
      @(negedge clock_in);
      chk(irq, 8'h00);
      // Controller node: role settles first, then events are ignored
      target = 1'b0;
      repeat (3) @(negedge clock_in);
      pulse(4'h1);
      @(negedge clock_in);
      chk({irq, rate}, 8'h00);
      rd_reg(ADDR_LOCAL_INTERRUPT_CAUSE, 1'b0, CAUSE_MBOX0_EMPTY);
      rd_reg(8'h31, 1'b1, 8'h00); // Unmapped offset reads zero
      repeat (3) @(negedge clock_in);
      if (exp_q.size() != 0) chk(8'hee, 8'h00); // Read never answered
      results();
   end
endmodule : txb_local_irq_i2c_cfg_regs_test

// ===== bench/txbli_proc_model.sv
// Processor on the far side of the serial front end, one byte per access
module txbli_proc_model (
   input wire logic clock_in,
   output logic reg_wr_out,
   output logic reg_rd_out,
   output logic reg_from_local_out,
   output logic [7:0] reg_addr_out,
   output logic [7:0] reg_wdata_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle port from time zero
   initial begin
      reg_wr_out = 1'b0;
      reg_rd_out = 1'b0;
      reg_from_local_out = 1'b0;
      reg_addr_out = 8'h00;
      reg_wdata_out = 8'h00;
   end
   // Strobe held one whole cycle, launched off the falling edge
   task automatic access(input logic wr, input logic rd, input logic loc,
         input logic [7:0] addr, input logic [7:0] data);
      @(negedge clock_in);
      reg_wr_out <= wr;
      reg_rd_out <= rd;
      reg_from_local_out <= loc;
      reg_addr_out <= addr;
      reg_wdata_out <= data;
      @(negedge clock_in);
      reg_wr_out <= 1'b0;
      reg_rd_out <= 1'b0;
      // Released lines inverted, so stale values are never trusted
      reg_from_local_out <= ~loc;
      reg_addr_out <= ~addr;
      reg_wdata_out <= ~data;
   endtask : access
endmodule : txbli_proc_model

// ===== hw/txbli_regs.sv
module txbli_regs
   import txbli_pkg::*;
(
   input wire logic clock_in,
   input wire logic srst_in,
   input wire logic node_is_target_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic reg_from_local_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   output logic [7:0] reg_rdata_out,
   output logic reg_rvalid_out,
   input wire logic mbox0_full_in,
   input wire logic mbox0_empty_in,
   input wire logic mbox1_full_in,
   input wire logic mbox1_empty_in,
   output logic irq_out,
   output logic tx_b_override_enable_out,
   output logic [1:0] tx_b_drive_level_out,
   output logic audio_sample_rate_select_out
);

   // Synchroniser for the node role pin
   logic target_meta; // First stage, read only by second
   logic target_sync; // Safe to use
   // Only the stored bits of each register exist here
   // Register contents
   logic [7:0] line_tx_b_control;
   logic [7:0] local_irq_cause;
   logic audio_sample_rate_select;
   logic irq_pending; // Pending local interrupt
   // Strobes qualified by address; the clearing read also by source and role
   // Decoded accesses
   logic wr_tx_b;
   logic wr_cfg;
   logic rd_cause_local;
   logic any_event;
   logic [7:0] next_cause;
   logic [1:0] next_level;

   // Codes are fixed per mailbox event, not by arrival order
   // Picks the cause code; lowest code wins if events coincide
   function automatic logic [7:0] txbli_cause(input logic [3:0] ev);
      logic [7:0] code;
      code = RESET_CAUSE;
      if (ev[0]) begin
         code = CAUSE_MBOX0_FULL;
      end else if (ev[1]) begin
         code = CAUSE_MBOX0_EMPTY;
      end else if (ev[2]) begin
         code = CAUSE_MBOX1_FULL;
      end else if (ev[3]) begin
         code = CAUSE_MBOX1_EMPTY;
      end
      return code;
   endfunction : txbli_cause

   // Maps control byte to applied drive level
   // Reserved code never reaches the analog driver
   function automatic logic [1:0] txbli_level(input logic [7:0] ctl);
      logic [1:0] lvl;
      lvl = ctl[TX_B_LEVEL_LSB +: 2];
      if (!ctl[TX_B_OVERRIDE_BIT]) begin
         lvl = DEFAULT_TX_B_LEVEL;
      end else if (lvl == TXBLI_LEVEL_RSVD) begin
         // Reserved code is not driven; fall back to default
         lvl = DEFAULT_TX_B_LEVEL;
      end
      return lvl;
   endfunction : txbli_level

   // Role pin comes from outside, two flops before use
   // Both stages reset so a stale role cannot leak out
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         target_meta <= 1'b0;
         target_sync <= 1'b0;
      end else begin
         target_meta <= node_is_target_in;
         target_sync <= target_meta;
      end
   end

   // Address decode
   // Write and read may share a cycle; decoded apart
   always_comb begin
      wr_tx_b = 1'b0;
      wr_cfg = 1'b0;
      rd_cause_local = 1'b0;
      if (reg_wr_in && reg_addr_in == ADDR_LINE_TX_B_CONTROL) begin
         wr_tx_b = 1'b1;
      end else if (reg_wr_in && reg_addr_in == ADDR_SERIAL_PORT_CONFIG) begin
         wr_cfg = 1'b1;
      end
      // Only the local processor of a target clears
      if (reg_rd_in && reg_addr_in == ADDR_LOCAL_INTERRUPT_CAUSE &&
          reg_from_local_in && target_sync) begin
         rd_cause_local = 1'b1;
      end
   end

   // Only mailbox events feed the cause register
   // Controller events are dropped at the pending flag
   assign any_event = mbox0_full_in | mbox0_empty_in |
                      mbox1_full_in | mbox1_empty_in;
   assign next_cause = txbli_cause({mbox1_empty_in, mbox1_full_in,
                                    mbox0_empty_in, mbox0_full_in});
   assign next_level = txbli_level(line_tx_b_control);

   // Transmitter B control register
   // Bits 6:2 read back as zero
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         line_tx_b_control <= RESET_TX_B_CONTROL;
      end else if (wr_tx_b) begin
         // Unused bits 6:2 are not kept
         line_tx_b_control <= reg_wdata_in & 8'h83;
      end
   end

   // Port configuration: only the rate bit is held here
   // Other config bits belong to the serial port itself
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         audio_sample_rate_select <= RESET_RATE_SELECT;
      end else if (wr_cfg) begin
         audio_sample_rate_select <= reg_wdata_in[SAMPLE_RATE_BIT];
      end
   end

   // Pending interrupt; new event wins over a clearing read
   // Cause byte survives a clear, so a reread still works
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         irq_pending <= 1'b0;
         local_irq_cause <= RESET_CAUSE;
      end else if (any_event && target_sync) begin
         irq_pending <= 1'b1;
         local_irq_cause <= next_cause;
      end else if (rd_cause_local) begin
         irq_pending <= 1'b0;
      end
   end

   // Register outputs toward pin and transmitter
   // All pins registered so decode glitches never escape
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         irq_out <= 1'b0;
         tx_b_override_enable_out <= 1'b0;
         tx_b_drive_level_out <= DEFAULT_TX_B_LEVEL;
         audio_sample_rate_select_out <= RATE_SEL_48K;
      end else begin
         // A clearing read loses to a same-cycle event, so no dip
         irq_out <= irq_pending && target_sync &&
            !(rd_cause_local && !any_event);
         tx_b_override_enable_out <= line_tx_b_control[TX_B_OVERRIDE_BIT];
         tx_b_drive_level_out <= next_level;
         // Controller node keeps the 48 kHz derivation
         audio_sample_rate_select_out <= target_sync ?
            audio_sample_rate_select : RATE_SEL_48K;
      end
   end

   // Read data, one cycle after the strobe
   // Data holds between reads for a slow serial shifter
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         reg_rdata_out <= 8'h00;
         reg_rvalid_out <= 1'b0;
      end else begin
         reg_rvalid_out <= reg_rd_in;
         if (!reg_rd_in) begin
            reg_rdata_out <= reg_rdata_out;
         end else if (reg_addr_in == ADDR_LINE_TX_B_CONTROL) begin
            reg_rdata_out <= line_tx_b_control;
         end else if (reg_addr_in == ADDR_LOCAL_INTERRUPT_CAUSE) begin
            reg_rdata_out <= local_irq_cause;
         end else if (reg_addr_in == ADDR_SERIAL_PORT_CONFIG) begin
            reg_rdata_out <= {5'h00, audio_sample_rate_select, 2'h0};
         end else begin
            reg_rdata_out <= 8'h00; // Unmapped reads give zero
         end
      end
   end

   // Checks; all on the one clock, silent while reset is held
   // Reset masks the first cycles, so $past never reads junk
   // Antecedents lean on internal decode so each check stays local
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (srst_in);

   // Override clear forces the default level out
   a_override_gate: assert property (
      !line_tx_b_control[TX_B_OVERRIDE_BIT] |=>
      tx_b_drive_level_out == DEFAULT_TX_B_LEVEL)
      else $error("level applied without override");

   // Override flag reaches its pin one cycle after storage
   a_override_pin: assert property (
      tx_b_override_enable_out ==
      $past(line_tx_b_control[TX_B_OVERRIDE_BIT]))
      else $error("override pin out of step");

   // Medium code held two cycles shows on the pins
   a_level_map: assert property (
      line_tx_b_control == 8'h82 ##1 line_tx_b_control == 8'h82 |->
      tx_b_drive_level_out == TXBLI_LEVEL_MEDIUM)
      else $error("medium level not applied");

   // Reserved code with override falls back to the default
   a_reserved_level: assert property (
      line_tx_b_control[TX_B_OVERRIDE_BIT] &&
      line_tx_b_control[TX_B_LEVEL_LSB +: 2] == TXBLI_LEVEL_RSVD |=>
      tx_b_drive_level_out == DEFAULT_TX_B_LEVEL)
      else $error("reserved level driven");

   // Event in a target shows on the pin two cycles on
   a_event_raises_irq: assert property (
      any_event && target_sync |-> ##2 irq_out || $past(rd_cause_local))
      else $error("irq not raised after event");

   // Pin only ever stands in a target node
   a_irq_target_only: assert property (
      irq_out |-> $past(target_sync))
      else $error("irq raised outside a target");

   // Local read without a new event drops pending and pin
   a_local_read_clears: assert property (
      rd_cause_local && !any_event |=> !irq_pending ##0 !irq_out)
      else $error("local read did not clear");

   // A clearing read loses to an event in the same cycle
   a_event_beats_clear: assert property (
      rd_cause_local && any_event && irq_pending |=>
      irq_pending && irq_out)
      else $error("event lost to clearing read");

   // Host reads leave the pending flag alone
   a_host_read_keeps: assert property (
      reg_rd_in && !reg_from_local_in && !any_event |=>
      $stable(irq_pending))
      else $error("host read changed pending");

   // Lone mailbox 1 empty event records its own code
   a_cause_code: assert property (
      target_sync && mbox1_empty_in && !mbox0_full_in && !mbox0_empty_in
      && !mbox1_full_in |=> local_irq_cause == 8'h33)
      else $error("wrong cause code");

   // Pending only ever rises on a mailbox event
   a_only_mailbox: assert property (
      $rose(irq_pending) |-> $past(any_event))
      else $error("pending without mailbox event");

   // Reads never disturb the cause byte
   a_cause_steady: assert property (
      !(any_event && target_sync) |=> $stable(local_irq_cause))
      else $error("cause moved without an event");

   // Rate bit lands from the written byte
   a_cfg_stored: assert property (
      wr_cfg |=>
      audio_sample_rate_select == $past(reg_wdata_in[SAMPLE_RATE_BIT]))
      else $error("config write lost");

   // Stored rate bit reaches the port in a target
   a_rate_select: assert property (
      audio_sample_rate_select && target_sync |=>
      audio_sample_rate_select_out == RATE_SEL_44K1)
      else $error("rate select not applied");

   // Controller node always derives the 48 kHz port clock
   a_rate_controller: assert property (
      !target_sync |=> audio_sample_rate_select_out == RATE_SEL_48K)
      else $error("rate select leaked in controller");

   // Port config writes never touch transmitter drive
   a_rate_isolated: assert property (
      wr_cfg && !wr_tx_b |=> ##1 $stable(tx_b_drive_level_out))
      else $error("config write moved transmitter");

   // Main scenarios: interrupt round trip, event racing a
   // clear, host read while pending, 44.1 kHz, low drive
   c_irq_cycle: cover property (
      any_event && target_sync ##[1:20] rd_cause_local);
   c_event_on_clear: cover property (rd_cause_local && any_event);
   c_host_read_pending: cover property (
      reg_rd_in && !reg_from_local_in && irq_pending);
   c_rate_44k1: cover property (audio_sample_rate_select_out);
   c_override_low: cover property (
      tx_b_drive_level_out == TXBLI_LEVEL_LOW);

endmodule : txbli_regs

// ===== shared/txbli_pkg.sv
package txbli_pkg;
   // Register offsets on the serial port
   localparam logic [7:0] ADDR_LINE_TX_B_CONTROL = 8'h30;
   localparam logic [7:0] ADDR_LOCAL_INTERRUPT_CAUSE = 8'h3e;
   localparam logic [7:0] ADDR_SERIAL_PORT_CONFIG = 8'h3f;
   // Field positions
   localparam int TX_B_OVERRIDE_BIT = 7;
   localparam int TX_B_LEVEL_LSB = 0;
   localparam int SAMPLE_RATE_BIT = 2;
   // Reset values
   localparam logic [7:0] RESET_TX_B_CONTROL = 8'h00;
   localparam logic [7:0] RESET_CAUSE = 8'h00;
   localparam logic RESET_RATE_SELECT = 1'b0;
   // Drive level encodings
   typedef enum logic [1:0] {
      TXBLI_LEVEL_HIGH = 2'h0,
      TXBLI_LEVEL_RSVD = 2'h1,
      TXBLI_LEVEL_MEDIUM = 2'h2,
      TXBLI_LEVEL_LOW = 2'h3
   } txbli_level_t;
   // Level used while override is off
   localparam logic [1:0] DEFAULT_TX_B_LEVEL = 2'h0;
   // Mailbox cause codes
   localparam logic [7:0] CAUSE_MBOX0_FULL = 8'h30;
   localparam logic [7:0] CAUSE_MBOX0_EMPTY = 8'h31;
   localparam logic [7:0] CAUSE_MBOX1_FULL = 8'h32;
   localparam logic [7:0] CAUSE_MBOX1_EMPTY = 8'h33;
   // Serial port clock ratio choices
   localparam logic RATE_SEL_48K = 1'b0;
   localparam logic RATE_SEL_44K1 = 1'b1;
endpackage : txbli_pkg
